// ### hw/irq_controller.sv
// interrupt flag, enable and vectoring controller with apb registers
`timescale 1ns/1ps
module irq_controller
	import irqc_pkg::*;
#(
	parameter int PA_W = 8,
	parameter int PB_W = 1
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            psel_i,
	input  wire logic            penable_i,
	input  wire logic            pwrite_i,
	input  wire logic [11:0]     paddr_i,
	input  wire logic [31:0]     pwdata_i,
	input  wire logic            ext_irq_pin_i,
	input  wire logic [3:0]      port_b_pins_i,
	input  wire logic [7:0]      eight_bit_timer_i,
	input  wire logic [PA_W-1:0] periph_evt_a_i,
	input  wire logic [PB_W-1:0] periph_evt_b_i,
	input  wire logic            boundary_i,
	input  wire logic            return_from_irq_instr_i,
	input  wire logic            sleep_i,
	input  wire logic [12:0]     ret_pc_i,
	output logic      [31:0]     prdata_o,
	output logic                 pready_o,
	output logic                 pslverr_o,
	output logic                 irq_o,
	output logic                 pc_load_o,
	output logic      [12:0]     pc_addr_o,
	output logic                 wake_o,
	output logic                 global_irq_enable_o
);
	typedef struct packed {
		logic [7:0]                   ctrl;
		logic [7:0]                   opt;
		logic [PA_W-1:0]              pfa;
		logic [PA_W-1:0]              pea;
		logic [PB_W-1:0]              pfb;
		logic [PB_W-1:0]              peb;
		logic [1:0]                   ist;
		logic [1:0]                   imsk;
		logic [STACK_DEPTH-1:0][12:0] stk;
		logic [SP_W-1:0]              sp;
		mode_type                     mode;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
		logic                         irq;
		logic                         pc_load;
		logic [12:0]                  pc_addr;
		logic                         wake;
	} state_type;

	state_type       state_reg;
	state_type       state_next;
	irq_event_if     ev ();
	logic [9:0]      idx;
	logic            hit;
	logic            wr;
	logic            pending;
	logic            take;
	logic [31:0]     rd;
	logic [1:0]      ist_evt;
	logic [1:0]      ist_clr;

	irq_event_detect irq_event_detect_inst (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pin_i      (ext_irq_pin_i),
		.edge_sel_i (state_reg.opt[EDGE_BIT]),
		.port_i     (port_b_pins_i),
		.timer_i    (eight_bit_timer_i),
		.ev         (ev.src)
	);

	// address decode; misaligned addresses count as unmapped
	assign idx = paddr_i[11:2];
	assign hit = (paddr_i[1:0] == 2'b00) && (idx == CTRL_IDX || idx == OPTION_IDX
	             || idx == PFA_IDX || idx == PFB_IDX || idx == PEA_IDX
	             || idx == PEB_IDX || idx == ISTAT_IDX || idx == IMASK_IDX);
	// writes land on the completing edge, when pready is already high
	assign wr  = psel_i && penable_i && state_reg.pready && pwrite_i && hit;

	// read data mux
	always_comb begin
		rd = 32'h0000_0000;
		case (idx)
			CTRL_IDX:   rd = {24'h00_0000, state_reg.ctrl};
			OPTION_IDX: rd = {24'h00_0000, state_reg.opt};
			PFA_IDX:    rd = 32'(state_reg.pfa);
			PFB_IDX:    rd = 32'(state_reg.pfb);
			PEA_IDX:    rd = 32'(state_reg.pea);
			PEB_IDX:    rd = 32'(state_reg.peb);
			ISTAT_IDX: begin
				rd            = 32'(state_reg.ist);
				rd[INSVC_BIT] = (state_reg.mode == MODE_SERVICE);
			end
			IMASK_IDX:  rd = 32'(state_reg.imsk);
			default:    rd = 32'h0000_0000;
		endcase
	end

	// any source with flag and enable; peripherals also need the group enable
	assign pending = (state_reg.ctrl[TIF_BIT] && state_reg.ctrl[TIE_BIT])
	               || (state_reg.ctrl[XIF_BIT] && state_reg.ctrl[XIE_BIT])
	               || (state_reg.ctrl[PCIF_BIT] && state_reg.ctrl[PCIE_BIT])
	               || (state_reg.ctrl[PERIPH_GROUP_ENABLE_BIT] && ((|(state_reg.pfa & state_reg.pea))
	                   || (|(state_reg.pfb & state_reg.peb))));
	// a return in the same cycle goes first; the vector follows later
	assign take = state_reg.ctrl[GIE_BIT] && pending && boundary_i && !return_from_irq_instr_i;

	// event status sources and write-one-to-clear mask
	assign ist_evt = {sleep_i && pending, take};
	assign ist_clr = (wr && idx == ISTAT_IDX) ? pwdata_i[1:0] : 2'b00;

	always_comb begin
		state_next         = state_reg;
		state_next.pready  = 1'b0;
		state_next.pslverr = 1'b0;
		state_next.pc_load = 1'b0;
		state_next.wake    = 1'b0;
		// one wait state: answer prepared in the first access cycle
		if (psel_i && penable_i && !state_reg.pready) begin
			state_next.pready  = 1'b1;
			state_next.pslverr = !hit;
			state_next.prdata  = (pwrite_i || !hit) ? 32'h0000_0000 : rd;
		end
		// software writes; flags written to zero clear, events still win
		if (wr && idx == CTRL_IDX) begin
			state_next.ctrl = pwdata_i[7:0];
		end
		if (wr && idx == OPTION_IDX) begin
			state_next.opt = pwdata_i[7:0];
		end
		if (wr && idx == PFA_IDX) begin
			state_next.pfa = pwdata_i[PA_W-1:0];
		end
		if (wr && idx == PFB_IDX) begin
			state_next.pfb = pwdata_i[PB_W-1:0];
		end
		if (wr && idx == PEA_IDX) begin
			state_next.pea = pwdata_i[PA_W-1:0];
		end
		if (wr && idx == PEB_IDX) begin
			state_next.peb = pwdata_i[PB_W-1:0];
		end
		if (wr && idx == IMASK_IDX) begin
			state_next.imsk = pwdata_i[1:0];
		end
		// flags set regardless of any enable
		state_next.ctrl[XIF_BIT]  = state_next.ctrl[XIF_BIT] | ev.ext_evt;
		state_next.ctrl[PCIF_BIT] = state_next.ctrl[PCIF_BIT] | ev.port_evt;
		state_next.ctrl[TIF_BIT]  = state_next.ctrl[TIF_BIT] | ev.tmr_evt;
		state_next.pfa = state_next.pfa | periph_evt_a_i;
		state_next.pfb = state_next.pfb | periph_evt_b_i;
		// vector entry: only the return address is stacked, flags untouched
		if (take) begin
			state_next.ctrl[GIE_BIT]  = 1'b0;
			state_next.stk[state_reg.sp] = ret_pc_i;
			state_next.sp      = state_reg.sp + 1'b1;
			state_next.pc_load = 1'b1;
			state_next.pc_addr = VECTOR_ADDR;
			state_next.mode    = MODE_SERVICE;
		end else if (return_from_irq_instr_i) begin
			// the stack is circular, like the core's; overflow is not flagged
			state_next.ctrl[GIE_BIT] = 1'b1;
			state_next.sp      = state_reg.sp - 1'b1;
			state_next.pc_load = 1'b1;
			state_next.pc_addr = state_reg.stk[state_reg.sp - 1'b1];
			state_next.mode    = MODE_MAIN;
		end
		// wake needs flag and enable only, never the global enable
		state_next.wake = sleep_i && pending;
		state_next.ist  = (state_reg.ist & ~ist_clr) | ist_evt;
		state_next.irq  = |(state_next.ist & state_next.imsk);
	end

	// reset clears the global enable with the rest of the control bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg      <= '0;
			state_reg.ctrl <= CTRL_RESET;
			state_reg.opt  <= OPTION_RESET;
			state_reg.mode <= MODE_MAIN;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata_o            = state_reg.prdata;
	assign pready_o            = state_reg.pready;
	assign pslverr_o           = state_reg.pslverr;
	assign irq_o               = state_reg.irq;
	assign pc_load_o           = state_reg.pc_load;
	assign pc_addr_o           = state_reg.pc_addr;
	assign wake_o              = state_reg.wake;
	assign global_irq_enable_o = state_reg.ctrl[GIE_BIT];

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic [12:0] top_q;
	assign top_q = state_reg.stk[state_reg.sp - 1'b1];

	sequence pin_flag_armed;
		ev.ext_evt ##1 (state_reg.ctrl[GIE_BIT] && state_reg.ctrl[XIE_BIT]);
	endsequence

	sequence boundary_seen;
		boundary_i && !return_from_irq_instr_i;
	endsequence

	// reset must leave vectoring blocked
	gie_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !global_irq_enable_o)
		else $error("global enable not cleared by reset");

	// entry is one step: vector load, enable clear and push together
	vector_entry_a: assert property (take |=> pc_load_o && pc_addr_o == VECTOR_ADDR
		&& !global_irq_enable_o && state_reg.sp == $past(state_reg.sp) + 1'b1)
		else $error("vector entry incomplete");

	// nothing may vector while the global enable is clear
	no_gie_block_a: assert property (!global_irq_enable_o && !return_from_irq_instr_i |=> !pc_load_o)
		else $error("vector taken with global enable clear");

	// return pops the address pushed last
	return_from_irq_instr_pop_a: assert property (return_from_irq_instr_i |=> pc_load_o && global_irq_enable_o
		&& pc_addr_o == $past(top_q))
		else $error("return did not restore address and enable");

	// flag plus boundary: the load follows on the next edge
	pin_latency_a: assert property (pin_flag_armed ##0 boundary_seen |=> pc_load_o)
		else $error("pin event not vectored in time");

	pin_flag_set_a: assert property (ev.ext_evt |=> state_reg.ctrl[XIF_BIT])
		else $error("pin flag not set");

	tmr_flag_set_a: assert property (ev.tmr_evt |=> state_reg.ctrl[TIF_BIT])
		else $error("timer flag not set");

	// a flag survives two cycles in which software leaves the register alone
	flag_sticky_a: assert property (state_reg.ctrl[PCIF_BIT] && !(wr && idx == CTRL_IDX)
		##1 !(wr && idx == CTRL_IDX) |-> state_reg.ctrl[PCIF_BIT][*2])
		else $error("port change flag lost");

	// a sleeping core is woken by flag and enable alone
	wake_req_a: assert property (sleep_i && pending |=> wake_o)
		else $error("wake not raised");

	// entry keeps the flag that caused it
	taken_keeps_flag_a: assert property (take && state_reg.ctrl[XIF_BIT] && !ist_clr[0]
		&& !(wr && idx == CTRL_IDX) |=> state_reg.ctrl[XIF_BIT] && state_reg.ist[TAKEN_BIT])
		else $error("entry cleared a flag");

	// a port change event lands in its flag one edge later
	port_flag_set_a: assert property (ev.port_evt |=> state_reg.ctrl[PCIF_BIT])
		else $error("port change flag not set");

	// peripheral events set their flags with no enable involved
	periph_a_set_a: assert property (periph_evt_a_i != '0 |=>
		(state_reg.pfa & $past(periph_evt_a_i)) == $past(periph_evt_a_i))
		else $error("peripheral flag a not set");

	// the second flag register follows the same rule
	periph_b_set_a: assert property (periph_evt_b_i != '0 |=>
		(state_reg.pfb & $past(periph_evt_b_i)) == $past(periph_evt_b_i))
		else $error("peripheral flag b not set");

	// an event only after the pin moved to the selected level
	edge_select_a: assert property (ev.ext_evt |->
		$past(ext_irq_pin_i) == $past(state_reg.opt[EDGE_BIT])
		&& $past(ext_irq_pin_i, 2) != $past(ext_irq_pin_i))
		else $error("pin event without a selected edge");

	// the stacked word is the return address offered at the take edge
	stack_push_a: assert property (take |=>
		state_reg.stk[$past(state_reg.sp)] == $past(ret_pc_i))
		else $error("return address not stacked");

	// entry marks the service routine as running
	service_mode_a: assert property (take |=> state_reg.mode == MODE_SERVICE)
		else $error("service mode not entered");

	// return leaves the service routine
	main_mode_a: assert property (return_from_irq_instr_i |=> state_reg.mode == MODE_MAIN)
		else $error("service mode not left");

	// a load strobe lasts one cycle unless a new entry or return follows
	load_pulse_a: assert property (pc_load_o && !take && !return_from_irq_instr_i |=> !pc_load_o)
		else $error("load strobe stretched");

	// no entry is ever taken with the global enable clear
	take_needs_gie_a: assert property (take |-> state_reg.ctrl[GIE_BIT])
		else $error("entry without global enable");

	// an armed request vectors at the first boundary that does not coincide with a return
	vector_now_a: assert property (state_reg.ctrl[GIE_BIT] && pending
		##0 boundary_seen |=> pc_load_o && pc_addr_o == VECTOR_ADDR)
		else $error("armed request not vectored");

	// reset selects the rising edge again
	option_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> state_reg.opt == OPTION_RESET)
		else $error("option register not reset");

	// with the global enable clear a wake-up continues in line, no vector
	wake_no_gie_a: assert property (sleep_i && pending && !state_reg.ctrl[GIE_BIT]
		&& !return_from_irq_instr_i |=> wake_o && !pc_load_o)
		else $error("wake-up without enable vectored");

	// wake-up is recorded in the event status
	wake_status_a: assert property (sleep_i && pending |=> state_reg.ist[WAKE_BIT])
		else $error("wake status not set");

	// entry leaves peripheral flags as they were
	periph_kept_a: assert property (take && state_reg.pfa != '0
		&& !(wr && idx == PFA_IDX)
		|=> state_reg.pfa == ($past(state_reg.pfa) | $past(periph_evt_a_i)))
		else $error("entry cleared a peripheral flag");
endmodule : irq_controller

// ### hw/irq_event_detect.sv
// edge, port change and timer rollover detection
`timescale 1ns/1ps
module irq_event_detect
	import irqc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       pin_i,
	input  wire logic       edge_sel_i,
	input  wire logic [3:0] port_i,
	input  wire logic [7:0] timer_i,
	irq_event_if.src        ev
);
	typedef struct packed {
		logic       primed;
		logic       pin;
		logic [3:0] port;
		logic [7:0] tmr;
		logic       ext;
		logic       chg;
		logic       ovf;
	} det_type;

	det_type    det_reg;
	det_type    det_next;
	logic [3:0] diff;

	// one compare per port bit
	for (genvar i = 0; i < 4; i++) begin : g_chg
		assign diff[i] = port_i[i] ^ det_reg.port[i];
	end

	// first cycle after reset only primes history, so no false event
	always_comb begin
		det_next        = det_reg;
		det_next.primed = 1'b1;
		det_next.pin    = pin_i;
		det_next.port   = port_i;
		det_next.tmr    = timer_i;
		det_next.ext    = det_reg.primed && (edge_sel_i ? (pin_i && !det_reg.pin)
		                                                : (!pin_i && det_reg.pin));
		det_next.chg    = det_reg.primed && (|diff);
		det_next.ovf    = det_reg.primed && det_reg.tmr == TMR_MAX
		                  && timer_i == TMR_ZERO;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			det_reg <= '0;
		end else begin
			det_reg <= det_next;
		end
	end

	assign ev.ext_evt  = det_reg.ext;
	assign ev.port_evt = det_reg.chg;
	assign ev.tmr_evt  = det_reg.ovf;
endmodule : irq_event_detect

// ### hw/irq_event_if.sv
// event pulses from the detector to the flag logic
`timescale 1ns/1ps
interface irq_event_if;
	logic ext_evt;
	logic port_evt;
	logic tmr_evt;
	modport src (output ext_evt, output port_evt, output tmr_evt);
	modport dst (input ext_evt, input port_evt, input tmr_evt);
endinterface : irq_event_if

// ### hw/irqc_pkg.sv
// shared constants and types of the interrupt controller
package irqc_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] CTRL_IDX   = 10'h00B;
	localparam logic [9:0] OPTION_IDX = 10'h081;
	localparam logic [9:0] PFA_IDX    = 10'h00C;
	localparam logic [9:0] PFB_IDX    = 10'h00D;
	localparam logic [9:0] PEA_IDX    = 10'h08C;
	localparam logic [9:0] PEB_IDX    = 10'h08D;
	localparam logic [9:0] ISTAT_IDX  = 10'h040;
	localparam logic [9:0] IMASK_IDX  = 10'h041;
	// control register fields, plus the edge select bit of the option register
	localparam int GIE_BIT   = 7;
	localparam int PERIPH_GROUP_ENABLE_BIT  = 6;
	localparam int TIE_BIT   = 5;
	localparam int XIE_BIT   = 4;
	localparam int PCIE_BIT  = 3;
	localparam int TIF_BIT   = 2;
	localparam int XIF_BIT   = 1;
	localparam int PCIF_BIT  = 0;
	localparam int EDGE_BIT  = 6;
	// event status fields
	localparam int TAKEN_BIT = 0;
	localparam int WAKE_BIT  = 1;
	localparam int INSVC_BIT = 4;
	// reset values and fixed figures
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [7:0]  OPTION_RESET = 8'hFF;
	localparam logic [12:0] VECTOR_ADDR  = 13'h0004;
	localparam logic [7:0]  TMR_MAX      = 8'hFF;
	localparam logic [7:0]  TMR_ZERO     = 8'h00;
	localparam int STACK_DEPTH = 8;
	localparam int SP_W        = 3;
	typedef enum logic {MODE_MAIN, MODE_SERVICE} mode_type;
endpackage : irqc_pkg

// ### verif/core_model.sv
// core sequencer model that answers vector loads and return requests
`timescale 1ns/1ps
module core_model
	import irqc_pkg::*;
#(
	parameter logic [12:0] START_PC = 13'h0123
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic        ret_req_i,
	input  wire logic        pc_load_i,
	input  wire logic [12:0] pc_addr_i,
	output logic             boundary_o,
	output logic             return_from_irq_instr_o,
	output logic      [12:0] ret_pc_o
);
	// slow mode offers a boundary every other cycle, as two-cycle instructions would
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			boundary_o <= 1'b0;
			return_from_irq_instr_o   <= 1'b0;
			ret_pc_o   <= START_PC;
		end else begin
			boundary_o <= slow_i ? ~boundary_o : 1'b1;
			return_from_irq_instr_o   <= ret_req_i;
			if (pc_load_i) begin
				ret_pc_o <= pc_addr_i; // program counter follows every load
			end
		end
	end
endmodule : core_model

// ### verif/mcu_interrupt_controller_test.sv
// self-checking bench for the interrupt controller with a core model
`timescale 1ns/1ps
module mcu_interrupt_controller_test
	import irqc_pkg::*;
;
	logic        clk_i, rst_i, psel, penable, pwrite, pin, sleep, slow, ret_req;
	logic        pready, pslverr, irq, pc_load, wake, global_irq_enable, boundary, return_from_irq_instr, s;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  port;
	logic [7:0]  tmr, pea;
	logic [0:0]  peb;
	logic [12:0] pc_addr, ret_pc;
	int          n_fail, comparisons, cycles, at;

	irq_controller irq_controller_inst (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.ext_irq_pin_i(pin), .port_b_pins_i(port), .eight_bit_timer_i(tmr),
		.periph_evt_a_i(pea), .periph_evt_b_i(peb), .boundary_i(boundary),
		.return_from_irq_instr_i(return_from_irq_instr), .sleep_i(sleep), .ret_pc_i(ret_pc), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .pc_load_o(pc_load),
		.pc_addr_o(pc_addr), .wake_o(wake), .global_irq_enable_o(global_irq_enable));
	core_model core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
		.ret_req_i(ret_req), .pc_load_i(pc_load), .pc_addr_i(pc_addr),
		.boundary_o(boundary), .return_from_irq_instr_o(return_from_irq_instr), .ret_pc_o(ret_pc));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// a hang ends the run through the same report
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : bus

	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic [31:0] r;
		logic        e;
		bus(1'b1, {i, 2'b00}, d, r, e);
	endtask : wr

	task automatic rd(input string n, input logic [9:0] i, input logic [7:0] x);
		logic [31:0] r;
		logic        e;
		repeat (3) @(posedge clk_i);
		bus(1'b0, {i, 2'b00}, 8'h00, r, e);
		chk(n, {24'h000000, x}, r);
	endtask : rd

	task automatic pin_to(input logic v);
		@(posedge clk_i);
		pin <= v;
	endtask : pin_to

	// counts edges until a vector or return load shows up
	task automatic wait_load(input int n, input logic x, input string nm);
		s  = 1'b0;
		at = 0;
		for (int i = 1; i <= n && !s; i++) begin
			@(posedge clk_i);
			#1;
			if (pc_load === 1'b1) begin
				s  = 1'b1;
				at = i;
			end
		end
		chk(nm, {31'h0, x}, {31'h0, s});
	endtask : wait_load

	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		rd("ctrl_reset", CTRL_IDX, CTRL_RESET); // global enable clear
		rd("option_reset", OPTION_IDX, 8'hFF); // rising edge default
		bus(1'b0, 12'hFFC, 8'h00, r, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
		bus(1'b1, 12'h02D, 8'h80, r, e);
		chk("misaligned_err", 32'h1, {31'h0, e});
		rd("ctrl_untouched", CTRL_IDX, 8'h00); // write ignored
	endtask : t_regs

	task automatic t_flags();
		pin_to(1'b1);
		rd("pin_flag", CTRL_IDX, 8'h02); // flag with no enables
		wr(CTRL_IDX, 8'h00);
		rd("flag_cleared", CTRL_IDX, 8'h00);
		wr(OPTION_IDX, 8'hBF);
		pin_to(1'b0);
		rd("falling_flag", CTRL_IDX, 8'h02);
		wr(CTRL_IDX, 8'h00);
		pin_to(1'b1);
		rd("rising_ignored", CTRL_IDX, 8'h00);
		wr(OPTION_IDX, 8'hFF);
		tmr <= 8'hFF;
		@(posedge clk_i);
		tmr <= 8'h00;
		rd("timer_flag", CTRL_IDX, 8'h04);
		wr(CTRL_IDX, 8'h00);
		port <= 4'hA;
		rd("port_flag", CTRL_IDX, 8'h01);
		wr(CTRL_IDX, 8'h00);
	endtask : t_flags

	task automatic t_vector();
		pin_to(1'b0);
		pin_to(1'b1);
		wr(CTRL_IDX, 8'h92);
		wait_load(8, 1'b1, "vector_load");
		chk("vector_addr", {19'h0, VECTOR_ADDR}, {19'h0, pc_addr});
		chk("gie_taken", 32'h0, {31'h0, global_irq_enable});
		rd("flag_kept", CTRL_IDX, 8'h12);
		rd("status_taken", ISTAT_IDX, 8'h11);
		wr(CTRL_IDX, 8'h10);
		@(posedge clk_i);
		ret_req <= 1'b1;
		@(posedge clk_i);
		ret_req <= 1'b0;
		wait_load(6, 1'b1, "return_load");
		chk("return_addr", 32'h0123, {19'h0, pc_addr});
		chk("gie_return", 32'h1, {31'h0, global_irq_enable});
		wr(IMASK_IDX, 8'h01);
		rd("status_mask", IMASK_IDX, 8'h01);
		chk("irq_raised", 32'h1, {31'h0, irq});
		wr(ISTAT_IDX, 8'h01);
		rd("status_w1c", ISTAT_IDX, 8'h00);
		chk("irq_cleared", 32'h0, {31'h0, irq});
	endtask : t_vector

	task automatic t_latency();
		pin_to(1'b0);
		pin_to(1'b1);
		wait_load(6, 1'b1, "fast_load");
		chk("latency_fast", 32'd3, at);
		wr(CTRL_IDX, 8'h90);
		slow <= 1'b1;
		pin_to(1'b0);
		pin_to(1'b1);
		wait_load(6, 1'b1, "slow_load");
		chk("latency_slow", 32'h1, {31'h0, at == 3 || at == 4});
		slow <= 1'b0;
		wr(CTRL_IDX, 8'h00);
	endtask : t_latency

	task automatic t_periph();
		pea <= 8'h01;
		peb <= 1'b1;
		@(posedge clk_i);
		pea <= 8'h00;
		peb <= 1'b0;
		rd("pflag_a", PFA_IDX, 8'h01);
		rd("pflag_b", PFB_IDX, 8'h01);
		wr(PEA_IDX, 8'h01);
		wr(CTRL_IDX, 8'h80);
		wait_load(8, 1'b0, "no_group_load"); // group enable gates
		wr(CTRL_IDX, 8'hC0);
		wait_load(8, 1'b1, "group_load");
		wr(PFA_IDX, 8'h00);
		wr(PFB_IDX, 8'h00);
		wr(CTRL_IDX, 8'h10);
	endtask : t_periph

	task automatic t_wake();
		sleep <= 1'b1;
		pin_to(1'b0);
		pin_to(1'b1);
		wait_load(5, 1'b0, "sleep_no_vector");
		chk("wake", 32'h1, {31'h0, wake});
		rd("wake_flag", CTRL_IDX, 8'h12);
		rd("status_wake", ISTAT_IDX, 8'h13);
		sleep <= 1'b0;
	endtask : t_wake

	// a mid-run reset must drop a set global enable and the event status
	task automatic t_reset();
		wr(CTRL_IDX, 8'h80);
		@(posedge clk_i);
		chk("gie_set", 32'h1, {31'h0, global_irq_enable});
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("gie_in_reset", 32'h0, {31'h0, global_irq_enable});
		rd("ctrl_after_reset", CTRL_IDX, CTRL_RESET);
		rd("status_after_reset", ISTAT_IDX, 8'h00);
		chk("irq_after_reset", 32'h0, {31'h0, irq});
	endtask : t_reset

	// inputs settle at time zero; reset held four cycles
	initial begin
		{rst_i, psel, penable, pwrite, pin, sleep, slow, ret_req} = 8'h80;
		{paddr, pwdata, port, tmr, pea, peb} = '0;
		{n_fail, comparisons, cycles} = '0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_flags();
		t_vector();
		t_latency();
		t_periph();
		t_wake();
		t_reset();
		wrap_up();
	end
endmodule : mcu_interrupt_controller_test
